// File: pkg/lcsm_cfg.svh
`ifndef LCSM_CFG_SVH
`define LCSM_CFG_SVH

// Clock and time base.
`define CLK_NS 25
`define SEC_NS 1000000000
`define CYC_PER_SEC (`SEC_NS / `CLK_NS)
// In-band codes, written leftmost bit first.
`define IB_ARM_CODE 16'h0018
`define IB_ARM_LEN 5
`define IB_DISARM_CODE 16'h001C
`define IB_DISARM_LEN 5
`define ACT_CENTRAL_CODE 16'hD3D3
`define ACT_REMOTE_CODE 16'hC742
`define DEACT_CODE 16'h9393
`define CODE16_LEN 16
// Data link words as written; the rightmost bit arrives first.
`define ESF_ARM_WORD 16'h12FF
`define ESF_DISARM_WORD 16'h24FF
`define ESF_REPS 3'h4
// Hold times in whole seconds; more than N seconds is N plus one.
`define ARM_HOLD_S 3'h5
`define DISARM_HOLD_S 3'h5
`define ACT_HOLD_S 3'h5
`define DEACT_HOLD_S 3'h6
// Mismatches allowed per second: 8000 framing overwrites plus 1608 line errors.
`define ERR_LIMIT 16'h2588
// Timeouts and buffer depth.
`define ARM_TO_H 2
`define ARM_TO_S (`ARM_TO_H * 3600)
`define LU_TO_M1 20
`define LU_TO_M2 60
`define LU_TO_M3 120
`define LU_TO_S1 (`LU_TO_M1 * 60)
`define LU_TO_S2 (`LU_TO_M2 * 60)
`define LU_TO_S3 (`LU_TO_M3 * 60)
`define FIFO_DEPTH 16
`endif

// File: pkg/lcsm_pkg.sv
package lcsm_pkg;
   typedef enum logic [3:0] {
      ST_DIS = 4'h1,
      ST_ARM = 4'h2,
      ST_LU = 4'h4,
      ST_LUN = 4'h8
   } lcsm_state_t;

   typedef struct packed {
      logic [15:0] sr;
      logic [3:0] ph;
      logic seen;
      logic [15:0] err;
      logic [31:0] pre;
      logic [2:0] secs;
      logic hit;
   } lcsm_det_t;

   typedef struct packed {
      lcsm_state_t st;
      logic [31:0] pre;
      logic [12:0] secs;
      logic [15:0] dl_sr;
      logic [3:0] dl_ph;
      logic [2:0] dl_cnt;
      logic dl_code;
      logic dl_lock;
      logic network_interface_unit;
      logic loop;
      logic flush;
      logic dn_bit;
      logic dn_valid;
      logic net_bit;
      logic net_valid;
      logic cust_ready;
   } lcsm_top_st_t;
endpackage : lcsm_pkg

// File: hdl/lcsm_fifo.sv
`timescale 1ns/1ps
module lcsm_fifo #(
   parameter int unsigned W = 1,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned AW = $clog2(DEPTH);
   // Pointers wrap naturally, so DEPTH must be a power of two.
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } lcsm_fifo_st_t;

   lcsm_fifo_st_t s;
   lcsm_fifo_st_t n;
   logic [W-1:0] mem [DEPTH];
   logic wr;
   logic rd;

   // Handshake terms; a flush drops both sides for the cycle.
   assign in_ready = s.cnt != (AW+1)'(DEPTH);
   assign out_valid = s.cnt != '0;
   assign out_data = mem[s.rp];
   assign level = s.cnt;
   assign wr = ce && !flush && in_valid && in_ready;
   assign rd = ce && !flush && out_valid && out_ready;

   // Next pointers and fill count.
   always_comb begin
      n = s;
      if (ce && flush) begin
         n = '0;
      end else begin
         if (wr) begin
            n.wp = s.wp + 1'b1;
         end
         if (rd) begin
            n.rp = s.rp + 1'b1;
         end
         if (wr && !rd) begin
            n.cnt = s.cnt + 1'b1;
         end else if (rd && !wr) begin
            n.cnt = s.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[s.wp] <= in_data;
      end
   end

   fifo_count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      s.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
   fifo_full_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!in_ready && !rd && !(ce && flush)) |=> !in_ready) else $error("full fifo lost fill");
endmodule : lcsm_fifo

// File: hdl/lcsm_det.sv
`timescale 1ns/1ps
`include "lcsm_cfg.svh"
module lcsm_det import lcsm_pkg::*; #(
   parameter int unsigned LEN = 5,
   parameter logic [15:0] CODE = 16'h0018,
   parameter logic [2:0] HOLD = 3'h5,
   parameter int unsigned CYC_PER_SEC = 40000000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic en,
   input wire logic bit_in,
   input wire logic bit_valid,
   output logic hit
);
   localparam logic [15:0] MASK = 16'hFFFF >> (16 - LEN);
   // A short window cannot carry the full per-second budget, or a foreign code that
   // merely contains this one would pass; cap it at one bit in eight of the window.
   localparam int unsigned ERR_MAX = (CYC_PER_SEC / 8 < `ERR_LIMIT) ? CYC_PER_SEC / 8 : `ERR_LIMIT;

   lcsm_det_t s;
   lcsm_det_t n;
   logic [15:0] sr_sh;
   logic [3:0] idx;

   assign hit = s.hit;

   // Phase-locked matcher: an exact code sets phase, then each bit is checked
   // against the code; framing overwrites and line errors only add mismatches.
   always_comb begin
      n = s;
      sr_sh = {s.sr[14:0], bit_in} & MASK;
      idx = 4'(LEN - 1) - s.ph;
      if (ce) begin
         if (!en) begin
            n = '0;
         end else begin
            if (bit_valid) begin
               n.sr = sr_sh;
               if (sr_sh == CODE) begin
                  n.seen = 1'b1;
                  n.ph = 4'h0;
               end else begin
                  if (bit_in != CODE[idx] && s.err != 16'hFFFF) begin
                     n.err = s.err + 16'h0001;
                  end
                  n.ph = (s.ph == 4'(LEN - 1)) ? 4'h0 : s.ph + 4'h1;
               end
            end
            if (s.pre == CYC_PER_SEC - 1) begin
               n.pre = '0;
               n.err = '0;
               n.seen = 1'b0;
               if (s.seen && s.err <= 16'(ERR_MAX)) begin
                  n.secs = (s.secs == HOLD) ? HOLD : s.secs + 3'h1;
               end else begin
                  n.secs = 3'h0;
               end
            end else begin
               n.pre = s.pre + 32'h1;
            end
            n.hit = n.secs == HOLD;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   det_hit_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(hit) |-> ($past(s.pre) == CYC_PER_SEC - 1 && $past(s.secs) == HOLD - 3'h1))
      else $error("hit rose off a second boundary");
   det_disable_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && !en) |=> (!hit && s.secs == 3'h0)) else $error("disabled detector kept count");
endmodule : lcsm_det

// File: hdl/lcsm_top.sv
`timescale 1ns/1ps
`include "lcsm_cfg.svh"
module lcsm_top import lcsm_pkg::*; #(
   parameter int unsigned CYC_PER_SEC = `CYC_PER_SEC
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic RX_BIT,
   input wire logic RX_VALID,
   input wire logic DL_BIT,
   input wire logic DL_VALID,
   input wire logic CUST_BIT,
   input wire logic CUST_VALID,
   input wire logic NET_READY,
   input wire logic NIU_OPT,
   input wire logic [1:0] LU_TO_SEL,
   output logic DN_BIT,
   output logic DN_VALID,
   output logic NET_BIT,
   output logic NET_VALID,
   output logic CUST_READY,
   output logic LOOP_ACTIVE,
   output logic NIU_LOOP,
   output logic [3:0] STATE
);
   localparam lcsm_top_st_t S_RST = '{st: ST_DIS, default: '0};

   logic rst_meta;
   logic rst_n_s;
   lcsm_top_st_t s;
   lcsm_top_st_t n;
   logic en_arm;
   logic en_act;
   logic en_deact;
   logic en_dis;
   logic arm_hit;
   logic act_hit;
   logic deact_hit;
   logic dis_hit;
   logic tick;
   logic esf_arm;
   logic esf_dis;
   logic m_any;
   logic m_dis;
   logic arm_evt;
   logic dis_evt;
   logic [15:0] dl_sr;
   logic [12:0] lim;
   logic f_in_valid;
   logic f_in_data;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_data;
   logic f_out_ready;
   logic [4:0] f_level;

   function automatic logic [12:0] lu_limit(input logic [1:0] sel);
      case (sel)
         2'h1: lu_limit = 13'(`LU_TO_S1);
         2'h2: lu_limit = 13'(`LU_TO_S2);
         2'h3: lu_limit = 13'(`LU_TO_S3);
         default: lu_limit = 13'h0000;
      endcase
   endfunction : lu_limit

   // Reset release through two flops; only the second is used.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'h0;
         rst_n_s <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n_s <= rst_meta;
      end
   end

   assign en_arm = s.st == ST_DIS;
   assign en_act = s.st == ST_ARM;
   assign en_deact = s.st == ST_LU || s.st == ST_LUN;
   assign en_dis = s.st != ST_DIS;

   lcsm_det #(.LEN(`IB_ARM_LEN), .CODE(`IB_ARM_CODE), .HOLD(`ARM_HOLD_S),
      .CYC_PER_SEC(CYC_PER_SEC)) u_arm (.clk(CLK_SYS), .rst_n(rst_n_s), .ce(CE),
      .en(en_arm), .bit_in(RX_BIT), .bit_valid(RX_VALID), .hit(arm_hit));
   lcsm_det #(.LEN(`CODE16_LEN), .CODE(`ACT_REMOTE_CODE), .HOLD(`ACT_HOLD_S),
      .CYC_PER_SEC(CYC_PER_SEC)) u_act (.clk(CLK_SYS), .rst_n(rst_n_s), .ce(CE),
      .en(en_act), .bit_in(RX_BIT), .bit_valid(RX_VALID), .hit(act_hit));
   lcsm_det #(.LEN(`CODE16_LEN), .CODE(`DEACT_CODE), .HOLD(`DEACT_HOLD_S),
      .CYC_PER_SEC(CYC_PER_SEC)) u_deact (.clk(CLK_SYS), .rst_n(rst_n_s), .ce(CE),
      .en(en_deact), .bit_in(RX_BIT), .bit_valid(RX_VALID), .hit(deact_hit));
   lcsm_det #(.LEN(`IB_DISARM_LEN), .CODE(`IB_DISARM_CODE), .HOLD(`DISARM_HOLD_S),
      .CYC_PER_SEC(CYC_PER_SEC)) u_dis (.clk(CLK_SYS), .rst_n(rst_n_s), .ce(CE),
      .en(en_dis), .bit_in(RX_BIT), .bit_valid(RX_VALID), .hit(dis_hit));

   assign f_in_valid = s.loop ? RX_VALID : CUST_VALID;
   assign f_in_data = s.loop ? RX_BIT : CUST_BIT;
   assign f_out_ready = !s.net_valid || NET_READY;

   lcsm_fifo #(.W(1), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .rst_n(rst_n_s),
      .ce(CE),
      .flush(s.flush),
      .in_valid(f_in_valid),
      .in_data(f_in_data),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out_data),
      .out_ready(f_out_ready),
      .level(f_level)
   );

   // Next-state logic for the whole element.
   always_comb begin
      n = s;
      tick = 1'b0;
      esf_arm = 1'b0;
      esf_dis = 1'b0;
      m_any = 1'b0;
      m_dis = 1'b0;
      dl_sr = s.dl_sr;
      lim = lu_limit(LU_TO_SEL);
      arm_evt = 1'b0;
      dis_evt = 1'b0;
      if (CE) begin
         n.dn_bit = RX_BIT;
         n.dn_valid = RX_VALID;
         if (s.pre == CYC_PER_SEC - 1) begin
            n.pre = '0;
            tick = 1'b1;
         end else begin
            n.pre = s.pre + 32'h1;
         end
         if (DL_VALID) begin
            dl_sr = {DL_BIT, s.dl_sr[15:1]};
            n.dl_sr = dl_sr;
            m_dis = dl_sr == `ESF_DISARM_WORD;
            m_any = m_dis || dl_sr == `ESF_ARM_WORD;
            if (!s.dl_lock) begin
               if (m_any) begin
                  n.dl_lock = 1'b1;
                  n.dl_ph = 4'h0;
                  n.dl_cnt = 3'h1;
                  n.dl_code = m_dis;
               end
            end else begin
               n.dl_ph = s.dl_ph + 4'h1;
               if (s.dl_ph == 4'hF) begin
                  if (m_any && m_dis == s.dl_code) begin
                     n.dl_cnt = s.dl_cnt + 3'h1;
                  end else if (m_any) begin
                     n.dl_cnt = 3'h1;
                     n.dl_code = m_dis;
                  end else begin
                     n.dl_lock = 1'b0;
                     n.dl_cnt = 3'h0;
                  end
               end
            end
            if (n.dl_cnt == `ESF_REPS) begin
               esf_arm = !n.dl_code;
               esf_dis = n.dl_code;
               n.dl_cnt = 3'h0;
               n.dl_lock = 1'b0;
            end
         end
         arm_evt = arm_hit || esf_arm;
         dis_evt = dis_hit || esf_dis;
         case (s.st)
            ST_DIS: begin
               if (arm_evt) begin
                  n.st = ST_ARM;
                  n.network_interface_unit = NIU_OPT;
               end
            end
            ST_ARM: begin
               if (dis_evt) begin
                  n.st = ST_DIS;
               end else if (act_hit) begin
                  n.st = (lim == 13'h0000) ? ST_LUN : ST_LU;
               end else if (tick && s.secs == 13'(`ARM_TO_S - 1)) begin
                  n.st = ST_DIS;
               end
            end
            ST_LU: begin
               if (dis_evt) begin
                  n.st = ST_DIS;
               end else if (deact_hit) begin
                  n.st = ST_ARM;
               end else if (tick && lim != 13'h0000 && s.secs == lim - 13'h0001) begin
                  n.st = ST_ARM;
               end
            end
            ST_LUN: begin
               if (dis_evt) begin
                  n.st = ST_DIS;
               end else if (deact_hit) begin
                  n.st = ST_ARM;
               end
            end
            default: begin
               n.st = ST_DIS;
            end
         endcase
         if (n.st == ST_DIS) begin
            n.network_interface_unit = 1'b0;
         end
         // timeout seconds restart on every state change
         if (n.st != s.st) begin
            n.secs = 13'h0000;
         end else if (tick) begin
            n.secs = s.secs + 13'h0001;
         end
         n.loop = n.st == ST_LU || n.st == ST_LUN;
         // flush path on any loop change
         n.flush = n.loop != s.loop;
         // Drop the output word on the edge the loop changes, so no bit of the old
         // path is shown under the new loop state.
         if (s.flush || n.flush) begin
            n.net_valid = 1'b0;
         end else if (f_out_ready) begin
            n.net_valid = f_out_valid;
            n.net_bit = f_out_data;
         end
         // One spare slot covers the cycle of lag on this ready.
         n.cust_ready = !n.loop && f_in_ready && f_level < 5'(`FIFO_DEPTH - 1);
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s <= S_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state register.
   assign DN_BIT = s.dn_bit;
   assign DN_VALID = s.dn_valid;
   assign NET_BIT = s.net_bit;
   assign NET_VALID = s.net_valid;
   assign CUST_READY = s.cust_ready;
   assign LOOP_ACTIVE = s.loop;
   assign NIU_LOOP = s.network_interface_unit;
   assign STATE = s.st;

   state_one_hot_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      $onehot(s.st)) else $error("state not one-hot");
   disarm_hold_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st == ST_DIS && !(CE && arm_evt)) |=> s.st == ST_DIS)
      else $error("left disarmed without arming");
   niu_loop_set_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st == ST_DIS && CE && arm_evt) |=> (NIU_LOOP == $past(NIU_OPT) && s.st == ST_ARM))
      else $error("interface loop not set on arming");
   arm_timeout_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st == ST_ARM && CE && tick && s.secs == 13'(`ARM_TO_S - 1) && !dis_evt && !act_hit)
      |=> s.st == ST_DIS) else $error("arming timeout missed");
   lu_timeout_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st == ST_LU && CE && tick && lim != 13'h0000 && s.secs == lim - 13'h0001
      && !dis_evt && !deact_hit) |=> s.st == ST_ARM) else $error("loop-up timeout missed");
   untimed_stay_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st == ST_LUN && !(CE && (dis_evt || deact_hit))) |=> s.st == ST_LUN)
      else $error("untimed loop-up left on its own");
   deact_return_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (en_deact && CE && deact_hit && !dis_evt) |=> (s.st == ST_ARM ##1 !LOOP_ACTIVE))
      else $error("deactivation not honoured");
   disarm_any_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (s.st != ST_DIS && CE && dis_evt) |=> (s.st == ST_DIS && !NIU_LOOP))
      else $error("disarm not honoured");
   loop_flush_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_s)
      (CE && $changed(LOOP_ACTIVE)) |-> (s.flush ##1 !NET_VALID))
      else $error("loop change without flush");
endmodule : lcsm_top

// File: verification/lcsm_net_model.sv
`timescale 1ns/1ps
module lcsm_net_model (
   input wire logic clk,
   input wire logic send,
   input wire logic ovw,
   input wire logic [15:0] code,
   input wire logic [4:0] len,
   output logic rx_bit,
   output logic rx_valid
);
   int pos = 0;
   int fcnt = 0;
   // Repeats the code one bit per cycle; when idle the line toggles so no stale value stands.
   always @(negedge clk) begin
      if (send) begin
         rx_bit <= (ovw && fcnt == 192) ? ~code[len - 1 - pos] : code[len - 1 - pos];
         rx_valid <= 1'b1;
         pos <= (pos + 1) % len;
         fcnt <= (fcnt + 1) % 193;
      end else begin
         rx_bit <= ~rx_bit;
         rx_valid <= 1'b0;
         pos <= 0;
      end
   end
   initial begin
      rx_bit = 1'b0;
      rx_valid = 1'b0;
   end
endmodule : lcsm_net_model

// File: verification/tb_loopback_code_state_machine.sv
`timescale 1ns/1ps
module tb_loopback_code_state_machine;
   import lcsm_pkg::*;
   localparam int C = 32;
   logic CLK_SYS = 1'b0, RST_N = 1'b0, DL_BIT = 1'b0, DL_VALID = 1'b0;
   logic CUST_BIT = 1'b1, CUST_VALID = 1'b0, NET_READY = 1'b1, NIU_OPT = 1'b1;
   logic [1:0] LU_TO_SEL = 2'h1;
   logic RX_BIT, RX_VALID, DN_BIT, DN_VALID, NET_BIT, NET_VALID, CUST_READY;
   logic LOOP_ACTIVE, NIU_LOOP, send = 1'b0, ovw = 1'b0, mon = 1'b0;
   logic [3:0] STATE;
   logic [15:0] code = 16'hFFFF;
   logic [4:0] len = 5'h10;
   int fails = 0;
   int n_compared = 0;

   lcsm_top #(.CYC_PER_SEC(C)) i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(1'b1),
      .RX_BIT(RX_BIT), .RX_VALID(RX_VALID), .DL_BIT(DL_BIT), .DL_VALID(DL_VALID),
      .CUST_BIT(CUST_BIT), .CUST_VALID(CUST_VALID), .NET_READY(NET_READY),
      .NIU_OPT(NIU_OPT), .LU_TO_SEL(LU_TO_SEL), .DN_BIT(DN_BIT), .DN_VALID(DN_VALID),
      .NET_BIT(NET_BIT), .NET_VALID(NET_VALID), .CUST_READY(CUST_READY),
      .LOOP_ACTIVE(LOOP_ACTIVE), .NIU_LOOP(NIU_LOOP), .STATE(STATE));
   lcsm_net_model i_net (.clk(CLK_SYS), .send(send), .ovw(ovw), .code(code), .len(len),
      .rx_bit(RX_BIT), .rx_valid(RX_VALID));

   // Clock of 25 ns period.
   initial begin
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end

   task automatic chk(input string n, input logic [3:0] seen, input logic [3:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic end_of_test();
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic wait_st(input logic [3:0] exp, input int max);
      for (int i = 0; i < max && STATE !== exp; i++) @(negedge CLK_SYS);
      chk("state", STATE, exp);
   endtask : wait_st

   task automatic tx(input logic [15:0] c, input logic [4:0] l, input logic o);
      @(negedge CLK_SYS) send <= 1'b0;
      @(negedge CLK_SYS) begin
         code <= c;
         len <= l;
         ovw <= o;
         send <= 1'b1;
      end
   endtask : tx

   // Sends one data link word, rightmost bit first, leaving the strobe high.
   task automatic dl_word(input logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         @(negedge CLK_SYS);
         DL_BIT = w[i];
         DL_VALID = 1'b1;
      end
   endtask : dl_word

   // Checks that every received bit comes out unchanged one cycle later.
   always @(negedge CLK_SYS) begin
      // Transparent data, and drained buffer words must carry the customer bit.
      if (mon && RX_VALID) chk("dn", {2'h0, DN_VALID, DN_BIT}, {3'h1, RX_BIT});
      if (mon && NET_VALID === 1'b1 && !LOOP_ACTIVE) chk("net_bit", NET_BIT, 1'b1);
   end

   task automatic t_fifo();
      NET_READY = 1'b0;
      CUST_VALID = 1'b1;
      repeat (40) @(negedge CLK_SYS);
      chk("cust_ready_full", CUST_READY, 1'b0);
      CUST_VALID = 1'b0;
      NET_READY = 1'b1;
      repeat (40) @(negedge CLK_SYS);
      chk("net_valid_empty", NET_VALID, 1'b0);
      chk("cust_ready_drained", CUST_READY, 1'b1);
   endtask : t_fifo

   task automatic t_ignore();
      tx(16'hC742, 5'h10, 1'b0);
      repeat (7 * C) @(negedge CLK_SYS);
      chk("state_ignored", STATE, 4'h1);
   endtask : t_ignore

   task automatic t_arm_inband();
      tx(16'h0018, 5'h5, 1'b0);
      repeat (3 * C) @(negedge CLK_SYS);
      chk("state_early", STATE, 4'h1);
      wait_st(4'h2, 8 * C);
      chk("niu_loop", NIU_LOOP, NIU_OPT);
   endtask : t_arm_inband

   task automatic t_act(input logic [1:0] sel, input logic [3:0] exp);
      LU_TO_SEL = sel;
      tx(16'hC742, 5'h10, 1'b1);
      wait_st(exp, 10 * C);
      repeat (10) @(negedge CLK_SYS);
      chk("loop_active", LOOP_ACTIVE, 1'b1);
      chk("net_valid_loop", NET_VALID, 1'b1);
      chk("cust_ready_loop", CUST_READY, 1'b0);
   endtask : t_act

   task automatic t_deact();
      tx(16'h9393, 5'h10, 1'b0);
      repeat (5 * C) @(negedge CLK_SYS);
      chk("state_deact_early", STATE, 4'h4);
      wait_st(4'h2, 6 * C);
      chk("loop_released", LOOP_ACTIVE, 1'b0);
   endtask : t_deact

   task automatic t_dl();
      tx(16'hFFFF, 5'h10, 1'b0);
      NIU_OPT = 1'b0;
      repeat (4) dl_word(16'h24FF);
      @(negedge CLK_SYS) DL_VALID = 1'b0;
      @(negedge CLK_SYS);
      chk("state_dl_disarm", STATE, 4'h1);
      chk("niu_released", NIU_LOOP, 1'b0);
      repeat (3) dl_word(16'h12FF);
      chk("state_dl_three", STATE, 4'h1);
      dl_word(16'h12FF);
      @(negedge CLK_SYS) DL_VALID = 1'b0;
      @(negedge CLK_SYS);
      chk("state_dl_arm", STATE, 4'h2);
      chk("niu_opt_off", NIU_LOOP, 1'b0);
   endtask : t_dl

   task automatic t_untimed_disarm();
      t_act(2'h0, 4'h8);
      tx(16'h001C, 5'h5, 1'b0);
      wait_st(4'h1, 8 * C);
      chk("loop_off", LOOP_ACTIVE, 1'b0);
   endtask : t_untimed_disarm

   task automatic t_timeout();
      t_dl();
      t_act(2'h1, 4'h4);
      tx(16'hFFFF, 5'h10, 1'b0);
      repeat (1197 * C) @(negedge CLK_SYS);
      chk("state_lu_held", STATE, 4'h4);
      wait_st(4'h2, 5 * C);
   endtask : t_timeout

   // Watchdog sized well past the longest expected run.
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      fails++;
      end_of_test();
   end

   initial begin
      repeat (10) @(negedge CLK_SYS);
      RST_N = 1'b1;
      repeat (5) @(negedge CLK_SYS);
      mon = 1'b1;
      // Reset state.
      chk("state_reset", STATE, 4'h1);
      chk("loops_reset", {LOOP_ACTIVE, NIU_LOOP}, 2'h0);
      t_fifo();
      t_ignore();
      t_arm_inband();
      t_act(2'h1, 4'h4);
      t_deact();
      t_dl();
      t_untimed_disarm();
      t_timeout();
      end_of_test();
   end
endmodule : tb_loopback_code_state_machine
